// *** common/flash_seq_defs.vh ***
// constants of the flash erase, program and protect block
`ifndef FLASH_SEQ_DEFS_VH
`define FLASH_SEQ_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL        4'h0
`define OFS_PROT        4'h4
`define OFS_STAT        4'h8
`define OFS_LATCH       4'hC
`define ARRAY_SEL_BIT   18

// ----------------------------------------
// control field positions
// ----------------------------------------
`define CTRL_PGM        0
`define CTRL_ERASE      1
`define CTRL_MASS       2
`define CTRL_HIGH_VOLTAGE_ENABLE       3

// ----------------------------------------
// status field positions
// ----------------------------------------
`define STAT_HVON       0
`define STAT_ARMED      1
`define STAT_BUSY       2

// ----------------------------------------
// reset values
// ----------------------------------------
`define PROT_RESET      8'hFF
`define ERASED_BYTE     8'hFF

// ----------------------------------------
// array geometry and protect setting limits
// ----------------------------------------
`define PAGE_LAST       17'h001FF
`define MASS_LAST       17'h0FFFF
`define OPTION_ADDR     16'hFFCF
`define PROT_NONE       8'hFF
`define PROT_VECT_MIN   8'hFC
`define PROT_ALL_MAX    8'h09

`endif

// *** hw/flash_protect_check.v ***
// protection decode for one array address
`timescale 1ns/1ps
`include "flash_seq_defs.vh"
module flash_protect_check (
    // protect setting
    input  wire [7:0]  protectStartBits,
    // address under test
    input  wire [15:0] addr,
    // result
    output reg         isProtected
);
    wire [15:0] startAddr = {protectStartBits[7:1], 9'h000};
    wire        alwaysProt = (addr >= `OPTION_ADDR);

    always @* begin
        if (protectStartBits == `PROT_NONE) begin
            isProtected = alwaysProt;
        end else if (protectStartBits >= `PROT_VECT_MIN) begin
            isProtected = alwaysProt;
        end else if (protectStartBits <= `PROT_ALL_MAX) begin
            isProtected = 1'b1;
        end else begin
            isProtected = alwaysProt | (addr >= startAddr);
        end
    end
endmodule // flash_protect_check

// *** hw/flash_array_mem.v ***
// byte array of the flash with registered read
`timescale 1ns/1ps
`include "flash_seq_defs.vh"
module flash_array_mem (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // write port
    input  wire        wrEn,
    input  wire        wrAndMode,
    input  wire [15:0] wrAddr,
    input  wire [7:0]  wrData,
    // read port
    input  wire [15:0] rdAddr,
    output reg  [7:0]  rdData
);
    reg [7:0] mem [0:65535];
    integer   i;

    // ----------------------------------------
    // delivered erased
    // ----------------------------------------
    initial begin
        for (i = 0; i < 65536; i = i + 1) begin
            mem[i] = `ERASED_BYTE;
        end
    end

    always @(posedge clk) begin
        if (wrEn) begin
            if (wrAndMode) begin
                mem[wrAddr] <= mem[wrAddr] & wrData;
            end else begin
                mem[wrAddr] <= wrData;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rdData <= `ERASED_BYTE;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule // flash_array_mem

// *** hw/flash_erase_program_protect.v ***
// flash erase, program and protect sequencer with AHB-Lite slave
`timescale 1ns/1ps
`include "flash_seq_defs.vh"
module flash_erase_program_protect (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // status
    output reg         highVoltageOn
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [1:0] ENG_IDLE  = 2'b01;
    localparam [1:0] ENG_ERASE = 2'b10;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg        pgm_reg;
    reg        erase_reg;
    reg        mass_reg;
    reg        high_voltage_enable_reg;
    reg        armed_reg;
    reg [7:0]  protect_reg;
    reg [15:0] latchAddr_reg;
    reg [7:0]  latchData_reg;
    reg        wrPend_reg;
    reg        rdPend_reg;
    reg [18:0] dpAddr_reg;
    reg [1:0]  engState_reg;
    reg        engMass_reg;
    reg [15:0] engBase_reg;
    reg [16:0] engCnt_reg;

    reg        pgm_next;
    reg        erase_next;
    reg        high_voltage_enable_next;

    wire [31:0] hrdata_next;
    wire        addrPhase = hsel & hready & htrans[1];
    wire        dpArray   = dpAddr_reg[`ARRAY_SEL_BIT];
    wire [15:0] dpByte    = dpAddr_reg[17:2];
    wire        ctrlWr    = wrPend_reg & ~dpArray & (dpAddr_reg[3:0] == `OFS_CTRL)
                            & (dpAddr_reg[17:4] == 14'h0000);
    wire        protWr    = wrPend_reg & ~dpArray & (dpAddr_reg[3:0] == `OFS_PROT)
                            & (dpAddr_reg[17:4] == 14'h0000);
    wire        arrWr     = wrPend_reg & dpArray;
    wire        selOn     = pgm_reg | erase_reg;
    wire        latchProt;
    wire        wrProt;
    wire        memWrEn;
    wire        memAnd;
    wire [15:0] memWrAddr;
    wire [7:0]  memWrData;
    wire [7:0]  memRdData;
    wire [15:0] engAddr   = engBase_reg + engCnt_reg[15:0];
    wire        engRun    = engState_reg[1];
    wire        engSkip   = ~engMass_reg & (engAddr >= `OPTION_ADDR);
    wire [16:0] engLast   = engMass_reg ? `MASS_LAST : `PAGE_LAST;
    wire        hvRefused = (erase_reg & mass_reg) ? (protect_reg != `PROT_NONE)
                                                   : latchProt;
    wire        pgmWr     = arrWr & pgm_reg & high_voltage_enable_reg & ~wrProt
                            & (dpByte[15:6] == latchAddr_reg[15:6]);

    // ----------------------------------------
    // protection checks
    // ----------------------------------------
    flash_protect_check protLatch (
        .protectStartBits (protect_reg),
        .addr             (latchAddr_reg),
        .isProtected      (latchProt)
    );

    flash_protect_check protWrite (
        .protectStartBits (protect_reg),
        .addr             (dpByte),
        .isProtected      (wrProt)
    );

    // ----------------------------------------
    // array
    // ----------------------------------------
    assign memWrEn   = (engRun & ~engSkip) | pgmWr;
    assign memAnd    = ~engRun;
    assign memWrAddr = engRun ? engAddr : dpByte;
    assign memWrData = engRun ? `ERASED_BYTE : hwdata[7:0];

    flash_array_mem arrayMem (
        .clk       (clk),
        .rst       (rst),
        .wrEn      (memWrEn),
        .wrAndMode (memAnd),
        .wrAddr    (memWrAddr),
        .wrData    (memWrData),
        .rdAddr    (haddr[17:2]),
        .rdData    (memRdData)
    );

    // ----------------------------------------
    // control bit updates
    // ----------------------------------------
    always @* begin
        pgm_next   = pgm_reg;
        erase_next = erase_reg;
        high_voltage_enable_next  = high_voltage_enable_reg;
        if (ctrlWr) begin
            if (!(hwdata[`CTRL_PGM] & hwdata[`CTRL_ERASE])) begin
                pgm_next   = hwdata[`CTRL_PGM];
                erase_next = hwdata[`CTRL_ERASE];
            end
            if (!hwdata[`CTRL_HIGH_VOLTAGE_ENABLE]) begin
                high_voltage_enable_next = 1'b0;
            end else if (!high_voltage_enable_reg) begin
                high_voltage_enable_next = selOn & armed_reg & ~hvRefused;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            pgm_reg       <= 1'b0;
            erase_reg     <= 1'b0;
            mass_reg      <= 1'b0;
            high_voltage_enable_reg      <= 1'b0;
            armed_reg     <= 1'b0;
            protect_reg   <= `PROT_RESET;
            latchAddr_reg <= 16'h0000;
            latchData_reg <= 8'h00;
        end else begin
            pgm_reg   <= pgm_next;
            erase_reg <= erase_next;
            high_voltage_enable_reg  <= high_voltage_enable_next;
            if (ctrlWr) begin
                mass_reg <= hwdata[`CTRL_MASS];
            end
            if (protWr) begin
                protect_reg <= hwdata[7:0];
            end
            if (!(pgm_next | erase_next)) begin
                armed_reg <= 1'b0;
            end else if (arrWr & selOn & ~high_voltage_enable_reg) begin
                armed_reg <= 1'b1;
            end
            if (arrWr & selOn) begin
                latchAddr_reg <= dpByte;
                latchData_reg <= hwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // erase engine
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            engState_reg <= ENG_IDLE;
            engMass_reg  <= 1'b0;
            engBase_reg  <= 16'h0000;
            engCnt_reg   <= 17'h00000;
        end else begin
            case (engState_reg)
                ENG_IDLE: begin
                    if (high_voltage_enable_next & ~high_voltage_enable_reg & erase_reg) begin
                        engState_reg <= ENG_ERASE;
                        engMass_reg  <= mass_reg;
                        engBase_reg  <= mass_reg ? 16'h0000
                                        : {latchAddr_reg[15:9], 9'h000};
                        engCnt_reg   <= 17'h00000;
                    end
                end
                ENG_ERASE: begin
                    if (engCnt_reg == engLast) begin
                        engState_reg <= ENG_IDLE;
                    end else begin
                        engCnt_reg <= engCnt_reg + 17'h00001;
                    end
                end
                default: begin
                    engState_reg <= ENG_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // ahb-lite slave
    // ----------------------------------------
    function [31:0] regRead;
        input [3:0] ofs;
        begin
            case (ofs)
                `OFS_CTRL:  regRead = {28'h0000000, high_voltage_enable_reg, mass_reg, erase_reg, pgm_reg};
                `OFS_PROT:  regRead = {24'h000000, protect_reg};
                `OFS_STAT:  regRead = {29'h00000000, engRun, armed_reg, high_voltage_enable_reg};
                `OFS_LATCH: regRead = {8'h00, latchData_reg, latchAddr_reg};
                default:    regRead = 32'h00000000;
            endcase
        end
    endfunction

    assign hrdata_next = dpArray ? {24'h000000, memRdData}
                       : ((dpAddr_reg[17:4] == 14'h0000) ? regRead(dpAddr_reg[3:0])
                                                         : 32'h00000000);

    always @(posedge clk) begin
        if (rst) begin
            wrPend_reg    <= 1'b0;
            rdPend_reg    <= 1'b0;
            dpAddr_reg    <= 19'h00000;
            hrdata        <= 32'h00000000;
            hreadyout     <= 1'b1;
            hresp         <= 1'b0;
            highVoltageOn <= 1'b0;
        end else begin
            highVoltageOn <= high_voltage_enable_next;
            hresp         <= 1'b0;
            wrPend_reg    <= addrPhase & hwrite;
            rdPend_reg    <= addrPhase & ~hwrite;
            if (addrPhase) begin
                dpAddr_reg <= haddr[18:0];
            end
            if (addrPhase & ~hwrite) begin
                hreadyout <= 1'b0;
            end else begin
                hreadyout <= 1'b1;
            end
            if (rdPend_reg) begin
                hrdata <= hrdata_next;
            end
        end
    end
endmodule // flash_erase_program_protect

// *** test/flash_seq_monitor.sv ***
// assertion checker for the flash sequencer bus and high voltage
`timescale 1ns/1ps
`include "flash_seq_defs.vh"
module flash_seq_monitor (
    // clock and reset
    input wire        clk,
    input wire        rst,
    // bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    // status
    input wire        highVoltageOn
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // bus phase tracking
    // ----------------------------------------
    reg        wrPh_reg;
    reg        rdPh_reg;
    reg [31:0] aPh_reg;
    reg [7:0]  prot_reg;
    wire take = hsel && hready && htrans[1];
    wire regPh = !aPh_reg[`ARRAY_SEL_BIT];
    wire wrCtrl = wrPh_reg && regPh && aPh_reg[3:0] == `OFS_CTRL;
    wire hvSetReq = wrCtrl && hwdata[`CTRL_HIGH_VOLTAGE_ENABLE];
    always @(posedge clk) begin
        if (rst) begin
            wrPh_reg <= 1'b0;
            rdPh_reg <= 1'b0;
            prot_reg <= `PROT_RESET;
        end else begin
            wrPh_reg <= take && hwrite;
            rdPh_reg <= take && !hwrite;
            if (take)
                aPh_reg <= haddr;
            if (wrPh_reg && regPh && aPh_reg[3:0] == `OFS_PROT)
                prot_reg <= hwdata[7:0];
        end
    end
    resp_okay_a: assert property (hresp == 1'b0) else $error("error response");
    write_nowait_a: assert property (wrPh_reg |-> hreadyout)
        else $error("write stalled");
    read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    rdata_hold_a: assert property (!rdPh_reg && !take |=> $stable(hrdata))
        else $error("read data moved");
    hv_cause_a: assert property ($rose(highVoltageOn) |-> $past(hvSetReq))
        else $error("high voltage rose unasked");
    hv_clear_a: assert property (wrCtrl && !hwdata[`CTRL_HIGH_VOLTAGE_ENABLE] |=> !highVoltageOn)
        else $error("high voltage not cleared");
    hv_protall_a: assert property (hvSetReq && !highVoltageOn &&
        prot_reg <= `PROT_ALL_MAX |=> !highVoltageOn) else $error("protected set taken");
    reset_vals_a: assert property ($fell(rst) |-> hreadyout &&
        hrdata == 32'h0 && !highVoltageOn) else $error("reset values wrong");
endmodule // flash_seq_monitor

// *** test/cpu_bus_model.sv ***
// bus master model of the cpu running the flash routine from ram
`timescale 1ns/1ps
module cpu_bus_model (
    // clock
    input wire        clk,
    // bus
    output reg        hsel,
    output reg [31:0] haddr,
    output reg [1:0]  htrans,
    output reg        hwrite,
    output reg [2:0]  hsize,
    output reg [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // ----------------------------------------
    // one word transfer, entered after an edge
    // ----------------------------------------
    task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (!hready) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : ~hwdata;
        @(posedge clk);
        while (!hready) @(posedge clk);
        q = hrdata;
    endtask
endmodule // cpu_bus_model

// *** test/tb_top.sv ***
// testbench of the flash erase, program and protect sequencer
`timescale 1ns/1ps
`include "flash_seq_defs.vh"
module tb_top;
    reg         clk;
    reg         rst;
    wire        hsel, hwrite, hreadyout, hresp, highVoltageOn;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0]  htrans;
    wire [2:0]  hsize;
    integer     num_errors, n_tests, cyc;
    reg  [31:0] q;
    localparam [31:0] A_CTRL = {28'h0, `OFS_CTRL};
    localparam [31:0] A_PROT = {28'h0, `OFS_PROT};
    localparam [31:0] A_STAT = {28'h0, `OFS_STAT};
    localparam [31:0] A_LAT = {28'h0, `OFS_LATCH};
    localparam [31:0] PROGRAM_SELECT = 32'h1 << `CTRL_PGM;
    localparam [31:0] ERS = 32'h1 << `CTRL_ERASE;
    localparam [31:0] HV = 32'h1 << `CTRL_HIGH_VOLTAGE_ENABLE;
    localparam [174:0] TBL = {8'h21, 16'h2000, 1'b0, 8'h21, 16'h1FC0, 1'b1, 8'h09, 16'h0100,
        1'b0, 8'hFF, 16'hFFD0, 1'b0, 8'hFC, 16'hFE00, 1'b1, 8'hFC, 16'hFFCF, 1'b0, 8'hFF,
        16'h0100, 1'b1};
    cpu_bus_model cpu (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
    flash_erase_program_protect DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .highVoltageOn(highVoltageOn));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [31:0] arr(input [15:0] b);
        arr = 32'h00040000 | {14'h0, b, 2'h0};
    endfunction
    task wr(input [31:0] a, input [31:0] d);
        cpu.xfer(1'b1, a, d, q);
    endtask
    task idle(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input [31:0] a, input [31:0] e);
        cpu.xfer(1'b0, a, 32'h0, q);
        n_tests = n_tests + 1;
        if (q !== e) begin
            num_errors = num_errors + 1;
            $display("BAD %0t read %h got %h exp %h", $time, a, q, e);
        end
    endtask
    task flag(input b, input e);
        n_tests = n_tests + 1;
        if (b !== e) begin
            num_errors = num_errors + 1;
            $display("BAD %0t high voltage %b exp %b", $time, b, e);
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        chk(A_PROT, {24'h0, `PROT_RESET});
        chk(arr(16'h3000), {24'h0, `ERASED_BYTE});
        chk(32'h00000010, 32'h0);
        wr(A_CTRL, PROGRAM_SELECT | ERS);
        chk(A_CTRL, 32'h0);
        wr(arr(16'h3001), 32'h0);
        chk(A_LAT, 32'h0);
    endtask
    task t_program;
        wr(A_CTRL, PROGRAM_SELECT);
        wr(A_CTRL, PROGRAM_SELECT | ERS);
        chk(A_CTRL, PROGRAM_SELECT);
        wr(arr(16'h1040), 32'h3C);
        chk(A_LAT, 32'h003C1040);
        idle(100);
        wr(A_CTRL, PROGRAM_SELECT | HV);
        chk(A_PROT, 32'hFF);
        chk(A_CTRL, PROGRAM_SELECT | HV);
        idle(200);
        wr(arr(16'h1041), 32'h5A);
        idle(400);
        wr(arr(16'h1081), 32'h0);
        idle(400);
        wr(A_CTRL, HV);
        idle(100);
        wr(A_CTRL, 32'h0);
        chk(arr(16'h1041), 32'h5A);
        chk(arr(16'h1081), 32'hFF);
        chk(arr(16'h1040), 32'hFF);
    endtask
    task t_protect;
        reg [24:0] c;
        integer    i;
        for (i = 6; i >= 0; i = i - 1) begin
            c = TBL[i*25 +: 25];
            wr(A_PROT, {24'h0, c[24:17]});
            wr(A_CTRL, PROGRAM_SELECT);
            wr(arr(c[16:1]), 32'hFF);
            wr(A_CTRL, PROGRAM_SELECT | HV);
            chk(A_CTRL, PROGRAM_SELECT | (c[0] ? HV : 32'h0));
            flag(highVoltageOn, c[0]);
            wr(A_CTRL, 32'h0);
        end
    endtask
    task t_erase;
        integer k;
        wr(A_CTRL, ERS);
        wr(A_CTRL, ERS | HV);
        chk(A_CTRL, ERS);
        wr(arr(16'h11FF), 32'h0);
        idle(100);
        wr(A_CTRL, ERS | HV);
        k = 0;
        q = 32'h1 << `STAT_BUSY;
        while (q[`STAT_BUSY] !== 1'b0 && k < 1000) begin
            cpu.xfer(1'b0, A_STAT, 32'h0, q);
            k = k + 1;
        end
        wr(A_CTRL, HV);
        idle(100);
        wr(A_CTRL, 32'h0);
        chk(arr(16'h1041), 32'hFF);
        wr(A_PROT, 32'h80);
        wr(A_CTRL, ERS | (32'h1 << `CTRL_MASS));
        wr(arr(16'h0200), 32'h0);
        wr(A_CTRL, ERS | HV | (32'h1 << `CTRL_MASS));
        chk(A_CTRL, ERS | (32'h1 << `CTRL_MASS));
        flag(highVoltageOn, 1'b0);
        wr(A_CTRL, 32'h0);
        wr(A_PROT, 32'hFF);
    endtask
    task print_verdict;
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        num_errors = 0;
        n_tests = 0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_program;
        t_protect;
        t_erase;
        print_verdict;
    end
    initial begin
        for (cyc = 0; cyc < 20000; cyc = cyc + 1) @(posedge clk);
        num_errors = num_errors + 1;
        print_verdict;
    end
endmodule // tb_top
bind flash_erase_program_protect flash_seq_monitor mon (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .highVoltageOn(highVoltageOn));
